// ---- sim/ems_and_wake_nmi_config_regs_tb_top.sv ----
`timescale 1ns/1ps
module ems_and_wake_nmi_config_regs_tb_top;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [15:0] io_addr;
   logic [7:0] io_wdata, io_rdata, q, page;
   logic io_wr, io_rd, io_ack, ack, req, lo, hi, m16, rtc, halt, hit, nmi, slp, fdc;
   logic [19:0] maddr;
   logic [1:0] bank;
   logic [3:0] ben, status, sclr;
   logic kbd, pwr, kclr;
   int fails = 0;
   int checks = 0;
   int i;
   initial forever #12.5 clk_i = ~clk_i;
   host_model host (.clk_i(clk_i), .io_ack_i(io_ack), .io_rdata_i(io_rdata),
      .io_addr_o(io_addr), .io_wdata_o(io_wdata), .io_wr_o(io_wr), .io_rd_o(io_rd));
   // short sleep divider keeps the run brief
   ems_and_wake_nmi_config_regs #(.SLEEP_HALF(2)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .io_addr_i(io_addr), .io_wdata_i(io_wdata), .io_wr_i(io_wr), .io_rd_i(io_rd),
      .io_rdata_o(io_rdata), .io_ack_o(io_ack), .mem_req_i(req), .mem_addr_i(maddr),
      .mem_bank_i(bank), .mem_low_byte_i(lo), .mem_high_byte_i(hi), .mode_16bit_i(m16),
      .bank_enable_o(ben), .window_hit_o(hit), .window_page_o(page),
      .rtc_wake_input_i(rtc), .keyboard_data_pin_i(kbd), .power_off_request_i(pwr),
      .kbd_clear_bit_i(kclr), .nmi_status_clear_i(sclr), .halt_i(halt),
      .nmi_status_o(status), .nmi_o(nmi), .sleep_clock_out_o(slp),
      .floppy_power_off_out_o(fdc));
   task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", n, exp, seen);
      end
   endtask : check
   task automatic acc(input logic w, input logic [15:0] a, input logic [7:0] d);
      host.xfer(w, a, d, ack, q);
   endtask : acc
   // memory cycle; registered answer is read one cycle on
   task automatic mem(input logic [19:0] a, input logic [1:0] b, input logic [2:0] lhm);
      @(negedge clk_i);
      {maddr, bank, req} = {a, b, 1'b1};
      {lo, hi, m16} = lhm;
      @(negedge clk_i);
      req = 1'b0;
   endtask : mem
   task automatic summarize();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : summarize
   initial begin
      {req, lo, hi, m16, rtc, halt, maddr, bank, kbd, pwr, kclr, sclr} = 35'h000000000;
      repeat (6) @(negedge clk_i);
      rst_n_i = 1'b1;
      acc(0, 16'h0072, 8'h00);
      check("ctrl_rst", q, 8'h00);
      check("ctrl_ack", 8'(ack), 8'h01);
      acc(1, 16'h0022, 8'h4C);
      acc(0, 16'h0023, 8'h00);
      check("ems_rst", q, 8'h00);
      acc(1, 16'h0072, 8'hFF);
      acc(0, 16'h0072, 8'h00);
      check("ctrl_rw", q, 8'h7E);
      check("fdc_on", 8'(fdc), 8'h01);
      acc(1, 16'h0072, 8'h00);
      @(negedge clk_i);
      check("fdc_off", 8'(fdc), 8'h00);
      $display("test control done");
      // clock must toggle while the off bit is clear, then stay low after halt
      q = 8'h00;
      repeat (8) @(negedge clk_i) q = q + 8'(slp);
      check("slp_run", 8'(q > 0 && q < 8), 8'h01);
      acc(1, 16'h0072, 8'h04);
      halt = 1'b1;
      @(negedge clk_i) halt = 1'b0;
      repeat (8) @(negedge clk_i) check("slp_off", 8'(slp), 8'h00);
      acc(1, 16'h0072, 8'h00);
      $display("test sleep done");
      // port select 5 gives 258h, base 1 gives c4000h
      acc(1, 16'h0022, 8'h4C);
      acc(1, 16'h0023, 8'h51);
      acc(0, 16'h0023, 8'h00);
      check("ems_rw", q, 8'h51);
      acc(1, 16'h0208, 8'h11);
      check("old_port", 8'(ack), 8'h00);
      acc(1, 16'h0258, 8'hA5);
      check("page_ack", 8'(ack), 8'h01);
      acc(1, 16'h4258, 8'h3C);
      acc(0, 16'h4258, 8'h00);
      check("page1_rd", q, 8'h3C);
      mem(20'hC0000, 2'h0, 3'h0);
      check("below", 8'(hit), 8'h00);
      mem(20'hC4000, 2'h0, 3'h0);
      check("pg0", page, 8'hA5);
      mem(20'hC8000, 2'h0, 3'h0);
      check("pg1", page, 8'h3C);
      mem(20'hD0000, 2'h0, 3'h0);
      check("pg3", 8'(hit), 8'h01);
      mem(20'hD4000, 2'h0, 3'h0);
      check("past", 8'(hit), 8'h00);
      mem(20'h00000, 2'h0, 3'h7);
      check("pair01", 8'(ben), 8'h03);
      mem(20'h00000, 2'h3, 3'h5);
      check("pair23_lo", 8'(ben), 8'h04);
      mem(20'h00000, 2'h3, 3'h6);
      check("bank8", 8'(ben), 8'h08);
      acc(1, 16'h0022, 8'h4D);
      acc(1, 16'h0023, 8'hFF);
      acc(0, 16'h0023, 8'h00);
      check("rsvd", q, 8'h00);
      $display("test window done");
      // rtc wake only reaches the processor once enabled
      rtc = 1'b1;
      repeat (5) @(negedge clk_i);
      check("rtc_off", 8'(nmi), 8'h00);
      acc(1, 16'h0072, 8'h08);
      for (i = 0; i < 20 && nmi !== 1'b1; i++) @(negedge clk_i);
      check("rtc_nmi", 8'(nmi), 8'h01);
      check("rtc_stat", 8'(status), 8'h01);
      // keyboard data sticks after its pin falls, suspend follows its pin
      acc(1, 16'h0072, 8'h30);
      {kbd, pwr} = 2'b11;
      repeat (4) @(negedge clk_i);
      check("kb_susp", 8'(status), 8'h06);
      {kbd, pwr} = 2'b00;
      repeat (4) @(negedge clk_i);
      check("kb_hold", 8'(status), 8'h02);
      sclr = 4'h2;
      @(negedge clk_i) sclr = 4'h0;
      check("kb_clr", 8'(status), 8'h00);
      acc(1, 16'h0072, 8'h40);
      kclr = 1'b1;
      @(negedge clk_i) kclr = 1'b0;
      check("kbclr", 8'(status), 8'h08);
      acc(1, 16'h00A3, 8'h00);
      @(negedge clk_i);
      check("masked", 8'(nmi), 8'h00);
      check("latched", 8'(status), 8'h08);
      $display("test nmi done");
      summarize();
   end
endmodule : ems_and_wake_nmi_config_regs_tb_top

// ---- sim/host_model.sv ----
`timescale 1ns/1ps
// ------------------------------------------
// host processor on the i/o bus
// ------------------------------------------
module host_model (
   input wire logic clk_i,
   input wire logic io_ack_i,
   input wire logic [7:0] io_rdata_i,
   output logic [15:0] io_addr_o,
   output logic [7:0] io_wdata_o,
   output logic io_wr_o,
   output logic io_rd_o
);
   initial begin
      {io_addr_o, io_wdata_o, io_wr_o, io_rd_o} = 26'h0000000;
   end
   // one-cycle strobe; ack and data taken one cycle later
   // callers send only matched bank pairs and unreserved selects
   task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] d,
                       output logic ack, output logic [7:0] q);
      @(negedge clk_i);
      io_addr_o = a;
      io_wdata_o = d;
      io_wr_o = w;
      io_rd_o = !w;
      @(negedge clk_i);
      ack = io_ack_i;
      q = io_rdata_i;
      io_wr_o = 1'b0;
      io_rd_o = 1'b0;
      io_addr_o = ~a; // a released bus keeps no stale address
      io_wdata_o = ~d;
   endtask : xfer
endmodule : host_model

// ---- src/ems_and_wake_nmi_config_regs.sv ----
`timescale 1ns/1ps
// Overview of operation
// (R1) 16-bit mode pairs banks 0/1 and 2/3, low byte even, high byte odd.
// (R2) software picks only configurations with matched bank pairs in 16-bit systems.
// (R3) index 4Ch read/write; upper nibble selects the page-register i/o port.
// (R4) page port decodes at 208h plus sixteen times the port select.
// (R5) software avoids the reserved port-select values.
// (R6) i/o address bits 15:14 pick one of four page registers.
// (R7) lower nibble sets window base C0000h plus value times 4000h, 0 to 8.
// (R8) up to three more 16k pages follow the base, four in all.
// (R9) indices 4Dh to 4Fh are reserved and hold nothing.
// (R10) nmi control is read/write port 72h with bits 7 and 0 reserved.
// (R11) keyboard-clear enable raises nmi when port 61 bit 7 is set.
// (R12) suspend enable low suppresses power-off nmi; high lets it through.
// (R13) keyboard-data enable raises nmi on each keyboard data pulse.
// (R14) rtc enable with rtc wake input high raises nmi.
// (R15) sleep clock off bit holds the sleep clock low after halt.
// (R16) floppy power bit drives the floppy power-off output directly.
// (R17) nmi control defined bits all read zero after reset.
// (R18) global nmi enable, bit 7 of ports A0h..AFh, masks the nmi output.
// (R19) nmi to the processor is the or of latched sources.
// (R20) expanded memory configuration resets to zero.
module ems_and_wake_nmi_config_regs #(
   parameter logic [15:0] CFG_INDEX_PORT = ems_nmi_pkg::CFG_INDEX_PORT_DEF,
   parameter logic [15:0] CFG_DATA_PORT = ems_nmi_pkg::CFG_DATA_PORT_DEF,
   parameter int PAGE_W = 8,
   parameter int SLEEP_HALF = ems_nmi_pkg::SLEEP_HALF_CYCLES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   // host i/o cycles
   input wire logic [15:0] io_addr_i,
   input wire logic [7:0] io_wdata_i,
   input wire logic io_wr_i,
   input wire logic io_rd_i,
   output logic [7:0] io_rdata_o,
   output logic io_ack_o,
   // host memory cycles
   input wire logic mem_req_i,
   input wire logic [19:0] mem_addr_i,
   input wire logic [1:0] mem_bank_i,
   input wire logic mem_low_byte_i,
   input wire logic mem_high_byte_i,
   input wire logic mode_16bit_i,
   output logic [3:0] bank_enable_o,
   output logic window_hit_o,
   output logic [PAGE_W-1:0] window_page_o,
   // wake, suspend and power pins
   input wire logic rtc_wake_input_i,
   input wire logic keyboard_data_pin_i,
   input wire logic power_off_request_i,
   input wire logic kbd_clear_bit_i,
   input wire logic [3:0] nmi_status_clear_i,
   input wire logic halt_i,
   output logic [3:0] nmi_status_o,
   output logic nmi_o,
   output logic sleep_clock_out_o,
   output logic floppy_power_off_out_o
);

   // ---------------------------------------------------------------
   // register file state
   // ---------------------------------------------------------------
   logic [7:0] cfg_index;
   logic [7:0] expanded_memory_config;
   logic [7:0] wake_nmi_power_control;
   logic global_nmi_enable;
   logic [PAGE_W-1:0] page_reg [ems_nmi_pkg::PAGES];
   logic [7:0] next_cfg_index;
   logic [7:0] next_expanded_memory_config;
   logic [7:0] next_wake_nmi_power_control;
   logic next_global_nmi_enable;
   logic [7:0] next_rdata;
   logic next_ack;

   logic [3:0] page_port_select;
   logic [3:0] page_window_base;
   logic [9:0] page_port;
   logic [1:0] page_idx;
   logic hit_index;
   logic hit_data;
   logic hit_nmi_ctrl;
   logic hit_global;
   logic hit_page;
   logic rsvd_index;

   assign page_port_select = expanded_memory_config[ems_nmi_pkg::PORT_SEL_LSB +: 4]; // [R3]
   assign page_window_base = expanded_memory_config[ems_nmi_pkg::BASE_SEL_LSB +: 4]; // [R7]

   // ---------------------------------------------------------------
   // i/o address decode
   // ---------------------------------------------------------------
   // page port sits in the low ten bits; bits 15:14 carry the page number,
   // so only bits 13:10 are required to be zero for a clean decode
   always_comb begin
      page_port = ems_nmi_pkg::PAGE_PORT_BASE + {2'b00, page_port_select, 4'h0}; // [R4]
      page_idx = io_addr_i[ems_nmi_pkg::PAGE_SEL_LSB +: 2]; // [R6]
      hit_index = (io_addr_i == CFG_INDEX_PORT);
      hit_data = (io_addr_i == CFG_DATA_PORT);
      hit_nmi_ctrl = (io_addr_i == ems_nmi_pkg::NMI_CTRL_PORT); // [R10]
      hit_global = (io_addr_i[15:4] == ems_nmi_pkg::GLOBAL_NMI_PORT_HI);
      hit_page = (io_addr_i[13:10] == 4'h0) && (io_addr_i[9:0] == page_port);
      rsvd_index = (cfg_index >= ems_nmi_pkg::RSVD_INDEX_LO)
                   && (cfg_index <= ems_nmi_pkg::RSVD_INDEX_HI);
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   // writes to reserved indices are dropped: nothing is stored there
   always_comb begin
      next_cfg_index = cfg_index;
      next_expanded_memory_config = expanded_memory_config;
      next_wake_nmi_power_control = wake_nmi_power_control;
      next_global_nmi_enable = global_nmi_enable;
      if (io_wr_i) begin
         if (hit_index) begin
            next_cfg_index = io_wdata_i;
         end
         if (hit_data && (cfg_index == ems_nmi_pkg::EMS_CFG_INDEX)) begin
            next_expanded_memory_config = io_wdata_i; // [R3] [R7]
         end
         if (hit_nmi_ctrl) begin
            next_wake_nmi_power_control = io_wdata_i & ems_nmi_pkg::NMI_CTRL_WMASK; // [R10]
         end
         if (hit_global) begin
            next_global_nmi_enable = io_wdata_i[ems_nmi_pkg::BIT_GLOBAL_NMI]; // [R18]
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cfg_index <= 8'h00;
         expanded_memory_config <= ems_nmi_pkg::EMS_CFG_RESET; // [R20]
         wake_nmi_power_control <= ems_nmi_pkg::NMI_CTRL_RESET; // [R17]
         global_nmi_enable <= ems_nmi_pkg::GLOBAL_NMI_RESET;
      end else begin
         cfg_index <= next_cfg_index;
         expanded_memory_config <= next_expanded_memory_config;
         wake_nmi_power_control <= next_wake_nmi_power_control;
         global_nmi_enable <= next_global_nmi_enable;
      end
   end

   // page registers keep their contents over reset like plain storage
   always_ff @(posedge clk_i) begin
      if (io_wr_i && hit_page) begin
         page_reg[page_idx] <= io_wdata_i[PAGE_W-1:0]; // [R6]
      end
   end

   // ---------------------------------------------------------------
   // register reads
   // ---------------------------------------------------------------
   // the global enable port is write-only and gives no read answer
   always_comb begin
      next_rdata = 8'h00;
      next_ack = 1'b0;
      if (io_rd_i) begin
         if (hit_index) begin
            next_rdata = cfg_index;
            next_ack = 1'b1;
         end else if (hit_data && (cfg_index == ems_nmi_pkg::EMS_CFG_INDEX)) begin
            next_rdata = expanded_memory_config;
            next_ack = 1'b1;
         end else if (hit_data && rsvd_index) begin
            next_rdata = 8'h00; // [R9]
            next_ack = 1'b1;
         end else if (hit_nmi_ctrl) begin
            next_rdata = wake_nmi_power_control; // [R10]
            next_ack = 1'b1;
         end else if (hit_page) begin
            next_rdata = 8'(page_reg[page_idx]);
            next_ack = 1'b1;
         end
      end else if (io_wr_i) begin
         next_ack = hit_index || hit_nmi_ctrl || hit_global || hit_page
                    || (hit_data && (rsvd_index || (cfg_index == ems_nmi_pkg::EMS_CFG_INDEX)));
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         io_rdata_o <= 8'h00;
         io_ack_o <= 1'b0;
      end else begin
         io_rdata_o <= next_rdata;
         io_ack_o <= next_ack;
      end
   end

   // ---------------------------------------------------------------
   // memory side: bank pairing and page window
   // ---------------------------------------------------------------
   logic win_hit;
   logic [1:0] win_page;
   logic [3:0] next_bank_enable;
   logic next_window_hit;
   logic [PAGE_W-1:0] next_window_page;

   ems_window_decode u_window (
      .clk_i (clk_i),
      .rst_n_i (rst_n_i),
      .base_sel_i (page_window_base),
      .mem_addr_i (mem_addr_i),
      .hit_o (win_hit),
      .page_o (win_page)
   );

   // software must program a valid paired layout; no check is made here
   always_comb begin
      next_bank_enable = 4'h0;
      next_window_hit = 1'b0;
      next_window_page = '0;
      if (mem_req_i) begin
         if (mode_16bit_i) begin
            next_bank_enable[{mem_bank_i[1], 1'b0}] = mem_low_byte_i; // [R1] [R2]
            next_bank_enable[{mem_bank_i[1], 1'b1}] = mem_high_byte_i; // [R1]
         end else begin
            next_bank_enable[mem_bank_i] = 1'b1;
         end
         next_window_hit = win_hit; // [R8]
         next_window_page = win_hit ? page_reg[win_page] : '0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bank_enable_o <= 4'h0;
         window_hit_o <= 1'b0;
         window_page_o <= '0;
      end else begin
         bank_enable_o <= next_bank_enable;
         window_hit_o <= next_window_hit;
         window_page_o <= next_window_page;
      end
   end

   // ---------------------------------------------------------------
   // nmi sources
   // ---------------------------------------------------------------
   nmi_group_if grp ();

   assign grp.enable[ems_nmi_pkg::SRC_RTC] = wake_nmi_power_control[ems_nmi_pkg::BIT_RTC_EN];
   assign grp.enable[ems_nmi_pkg::SRC_KEYBOARD_DATA_PIN] =
      wake_nmi_power_control[ems_nmi_pkg::BIT_KEYBOARD_DATA_PIN_EN];
   assign grp.enable[ems_nmi_pkg::SRC_SUSP] = wake_nmi_power_control[ems_nmi_pkg::BIT_SUSP_EN];
   assign grp.enable[ems_nmi_pkg::SRC_KBCLR] =
      wake_nmi_power_control[ems_nmi_pkg::BIT_KBCLR_EN];
   assign grp.global_enable = global_nmi_enable;
   assign grp.clear = nmi_status_clear_i;

   nmi_sources u_nmi (
      .clk_i (clk_i),
      .rst_n_i (rst_n_i),
      .rtc_wake_input_i (rtc_wake_input_i),
      .keyboard_data_pin_i (keyboard_data_pin_i),
      .power_off_request_i (power_off_request_i),
      .kbd_clear_bit_i (kbd_clear_bit_i),
      .grp (grp.src)
   );

   assign nmi_status_o = grp.status;
   assign nmi_o = grp.nmi;
   assign floppy_power_off_out_o = wake_nmi_power_control[ems_nmi_pkg::BIT_FLOPPY]; // [R16]

   // ---------------------------------------------------------------
   // sleep clock
   // ---------------------------------------------------------------
   typedef enum logic [0:0] {
      SLEEP_RUN = 1'b0,
      SLEEP_HELD = 1'b1
   } sleep_state_t;

   sleep_state_t sleep_state;
   sleep_state_t next_sleep_state;
   logic [7:0] sleep_cnt;
   logic [7:0] next_sleep_cnt;
   logic next_sleep_clock;

   // with the off bit set, halt parks the clock low; any delivered nmi, or clearing the bit, restarts it
   always_comb begin
      next_sleep_state = sleep_state;
      next_sleep_cnt = sleep_cnt;
      next_sleep_clock = sleep_clock_out_o;
      unique case (sleep_state)
         SLEEP_RUN: begin
            if (halt_i && wake_nmi_power_control[ems_nmi_pkg::BIT_SLEEP_OFF]) begin
               next_sleep_state = SLEEP_HELD; // [R15]
               next_sleep_clock = 1'b0;
               next_sleep_cnt = 8'h00;
            end else if (sleep_cnt == 8'(SLEEP_HALF - 1)) begin
               next_sleep_cnt = 8'h00;
               next_sleep_clock = ~sleep_clock_out_o;
            end else begin
               next_sleep_cnt = sleep_cnt + 8'h01;
            end
         end
         SLEEP_HELD: begin
            next_sleep_clock = 1'b0; // [R15]
            if (nmi_o || !wake_nmi_power_control[ems_nmi_pkg::BIT_SLEEP_OFF]) begin
               next_sleep_state = SLEEP_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sleep_state <= SLEEP_RUN;
         sleep_cnt <= 8'h00;
         sleep_clock_out_o <= 1'b0;
      end else begin
         sleep_state <= next_sleep_state;
         sleep_cnt <= next_sleep_cnt;
         sleep_clock_out_o <= next_sleep_clock;
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_halt_taken;
      halt_i && wake_nmi_power_control[ems_nmi_pkg::BIT_SLEEP_OFF] && (sleep_state == SLEEP_RUN);
   endsequence

   sequence s_clock_parked;
      (!sleep_clock_out_o && !nmi_o) [*4];
   endsequence

   a_sleep_parked : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R15]
      s_halt_taken ##1 (!nmi_o && wake_nmi_power_control[ems_nmi_pkg::BIT_SLEEP_OFF]) [*4]
      |-> ##1 (sleep_state == SLEEP_HELD) ##0 !sleep_clock_out_o)
      else $error("sleep clock running after halt");
   a_nmi_ctrl_reset : assert property (@(posedge clk_i) // [R17]
      !rst_n_i |=> (wake_nmi_power_control == 8'h00) && !floppy_power_off_out_o)
      else $error("nmi control not cleared by reset");
   a_ems_cfg_reset : assert property (@(posedge clk_i) // [R20]
      !rst_n_i |=> (expanded_memory_config == 8'h00))
      else $error("expanded_memory_config not cleared by reset");
   a_floppy_follows : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R16]
      (io_wr_i && hit_nmi_ctrl) |=> floppy_power_off_out_o == $past(io_wdata_i[1]))
      else $error("floppy power output does not follow write");
   a_ctrl_rsvd_zero : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R10]
      (io_rd_i && hit_nmi_ctrl) |=> io_ack_o && (io_rdata_o[7] == 1'b0)
      && (io_rdata_o[0] == 1'b0))
      else $error("reserved nmi control bits read nonzero");
   a_rsvd_index_zero : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R9]
      (io_rd_i && hit_data && rsvd_index && !hit_index) |=> io_ack_o && (io_rdata_o == 8'h00))
      else $error("reserved index returned data");
   a_page_port_decode : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
      hit_page |-> (io_addr_i[9:0] == 10'h208 + {2'b00, page_port_select, 4'h0})
      && (io_addr_i[3:0] == 4'h8))
      else $error("page port decoded at wrong address");
   a_bank_pairing : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
      (mem_req_i && mode_16bit_i) |=> (bank_enable_o[{$past(mem_bank_i[1]), 1'b0}]
      == $past(mem_low_byte_i)) && (bank_enable_o[{!$past(mem_bank_i[1]), 1'b0}] == 1'b0))
      else $error("16-bit bank pair enables wrong");
   a_window_page : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R7]
      (mem_req_i && (page_window_base > 4'h8)) |=> !window_hit_o)
      else $error("reserved base opened a window");

endmodule : ems_and_wake_nmi_config_regs

// ---- src/ems_nmi_pkg.sv ----
package ems_nmi_pkg;

   // ---------------------------------------------------------------
   // register locations
   // ---------------------------------------------------------------
   localparam logic [7:0] EMS_CFG_INDEX = 8'h4C;
   localparam logic [7:0] RSVD_INDEX_LO = 8'h4D;
   localparam logic [7:0] RSVD_INDEX_HI = 8'h4F;
   localparam logic [15:0] NMI_CTRL_PORT = 16'h0072;
   localparam logic [11:0] GLOBAL_NMI_PORT_HI = 12'h00A; // ports A0h..AFh
   localparam logic [15:0] CFG_INDEX_PORT_DEF = 16'h0022;
   localparam logic [15:0] CFG_DATA_PORT_DEF = 16'h0023;
   localparam logic [9:0] PAGE_PORT_BASE = 10'h208;

   // ---------------------------------------------------------------
   // field layouts
   // ---------------------------------------------------------------
   localparam int PORT_SEL_LSB = 4;
   localparam int BASE_SEL_LSB = 0;
   localparam int SEL_W = 4;
   localparam int PAGE_SEL_LSB = 14; // io address bits 15:14
   localparam logic [3:0] BASE_SEL_MAX = 4'h8;
   localparam logic [5:0] WINDOW_FIRST_BLOCK = 6'h30; // c0000h in 16k blocks
   localparam int BLOCK_LSB = 14;
   localparam int PAGES = 4;
   localparam int BIT_KBCLR_EN = 6;
   localparam int BIT_SUSP_EN = 5;
   localparam int BIT_KEYBOARD_DATA_PIN_EN = 4;
   localparam int BIT_RTC_EN = 3;
   localparam int BIT_SLEEP_OFF = 2;
   localparam int BIT_FLOPPY = 1;
   localparam int BIT_GLOBAL_NMI = 7;
   localparam logic [7:0] NMI_CTRL_WMASK = 8'h7E;

   // status / enable order inside the nmi group
   localparam int SRC_RTC = 0;
   localparam int SRC_KEYBOARD_DATA_PIN = 1;
   localparam int SRC_SUSP = 2;
   localparam int SRC_KBCLR = 3;
   localparam int SRC_N = 4;

   // ---------------------------------------------------------------
   // reset values and timing
   // ---------------------------------------------------------------
   localparam logic [7:0] EMS_CFG_RESET = 8'h00;
   localparam logic [7:0] NMI_CTRL_RESET = 8'h00;
   localparam logic GLOBAL_NMI_RESET = 1'b1;
   localparam int SLEEP_HALF_CYCLES = 20;

endpackage : ems_nmi_pkg

// ---- src/ems_window_decode.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// page window decoder
// ---------------------------------------------------------------
module ems_window_decode (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] base_sel_i,
   input wire logic [19:0] mem_addr_i,
   output logic hit_o,
   output logic [1:0] page_o
);
   logic [5:0] block;
   logic [5:0] first;
   logic [5:0] diff;

   // work in 16k blocks so the window edges are plain compares
   always_comb begin
      block = mem_addr_i[19:ems_nmi_pkg::BLOCK_LSB];
      first = ems_nmi_pkg::WINDOW_FIRST_BLOCK + {2'b00, base_sel_i}; // [R7]
      diff = block - first;
      // reserved base values open no window at all
      hit_o = (base_sel_i <= ems_nmi_pkg::BASE_SEL_MAX) && (block >= first)
              && (diff < 6'(ems_nmi_pkg::PAGES)); // [R8]
      page_o = diff[1:0];
   end

   // a hit must fall inside the four 16k pages above the base
   a_window_bounds : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R8]
      hit_o |-> (mem_addr_i >= {first, 14'h0000})
      && (mem_addr_i < ({first, 14'h0000} + 20'h10000))
      && (page_o == 2'(mem_addr_i[15:14] - base_sel_i[1:0])))
      else $error("window hit outside programmed pages");
endmodule : ems_window_decode

// ---- src/nmi_group_if.sv ----
`timescale 1ns/1ps
// enables, mask and latched sources shared by the register file and the nmi logic
interface nmi_group_if;
   logic [3:0] enable;
   logic global_enable;
   logic [3:0] clear;
   logic [3:0] status;
   logic nmi;
   modport regs (output enable, output global_enable, output clear,
                 input status, input nmi);
   modport src (input enable, input global_enable, input clear,
                output status, output nmi);
endinterface : nmi_group_if

// ---- src/nmi_sources.sv ----
`timescale 1ns/1ps
// ---------------------------------------------------------------
// wake and suspend nmi sources
// ---------------------------------------------------------------
module nmi_sources (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic rtc_wake_input_i,
   input wire logic keyboard_data_pin_i,
   input wire logic power_off_request_i,
   input wire logic kbd_clear_bit_i,
   nmi_group_if.src grp
);
   logic [1:0] sync [3];
   logic keyboard_data_pin_prev;
   logic [3:0] status;
   logic nmi;
   logic [3:0] next_status;
   logic next_nmi;
   logic [2:0] pins;

   assign pins = {power_off_request_i, keyboard_data_pin_i, rtc_wake_input_i};

   // two flops per pin; only the second stage is looked at
   for (genvar g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            sync[g] <= 2'b00;
         end else begin
            sync[g] <= {sync[g][0], pins[g]};
         end
      end
   end

   // level sources follow their input, pulse sources stick until cleared
   always_comb begin
      next_status[ems_nmi_pkg::SRC_RTC] = grp.enable[ems_nmi_pkg::SRC_RTC] & sync[0][1]; // [R14]
      next_status[ems_nmi_pkg::SRC_SUSP] = grp.enable[ems_nmi_pkg::SRC_SUSP] & sync[2][1]; // [R12]
      // set beats clear so a pulse in the clearing cycle is kept
      next_status[ems_nmi_pkg::SRC_KEYBOARD_DATA_PIN] = (status[ems_nmi_pkg::SRC_KEYBOARD_DATA_PIN]
         & ~grp.clear[ems_nmi_pkg::SRC_KEYBOARD_DATA_PIN])
         | (grp.enable[ems_nmi_pkg::SRC_KEYBOARD_DATA_PIN] & sync[1][1] & ~keyboard_data_pin_prev); // [R13]
      next_status[ems_nmi_pkg::SRC_KBCLR] = (status[ems_nmi_pkg::SRC_KBCLR]
         & ~grp.clear[ems_nmi_pkg::SRC_KBCLR])
         | (grp.enable[ems_nmi_pkg::SRC_KBCLR] & kbd_clear_bit_i); // [R11]
      // sources latch even while masked; only the output is gated
      next_nmi = grp.global_enable & (|status); // [R18] [R19]
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         status <= 4'h0;
         nmi <= 1'b0;
         keyboard_data_pin_prev <= 1'b0;
      end else begin
         status <= next_status;
         nmi <= next_nmi;
         keyboard_data_pin_prev <= sync[1][1];
      end
   end

   assign grp.status = status;
   assign grp.nmi = nmi;

   a_rtc_follows : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R14]
      (grp.enable[ems_nmi_pkg::SRC_RTC] && sync[0][1]) |=> status[ems_nmi_pkg::SRC_RTC])
      else $error("rtc wake not latched");
   a_suspend_blocked : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
      !grp.enable[ems_nmi_pkg::SRC_SUSP] |=> !status[ems_nmi_pkg::SRC_SUSP])
      else $error("suspend nmi passed while disabled");
   a_keyboard_data_pin_pulse : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R13]
      (grp.enable[ems_nmi_pkg::SRC_KEYBOARD_DATA_PIN] && $rose(sync[1][1]))
      |=> status[ems_nmi_pkg::SRC_KEYBOARD_DATA_PIN])
      else $error("keyboard data pulse lost");
   a_nmi_is_or : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R19]
      (grp.global_enable && (|status)) |=> nmi)
      else $error("nmi missing for latched source");
   a_global_mask : assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R18]
      (!grp.global_enable && (|status)) |=> !nmi ##0 (|$past(status)))
      else $error("masked nmi reached processor");
endmodule : nmi_sources
